// ### hdl/ssr_glitch_filter.sv
// Two-sided glitch filter: output follows input only after a stable run
`timescale 1ns/1ns
module ssr_glitch_filter #(
  parameter int unsigned W = 16,
  parameter logic [W-1:0] SET_CYC = 16'h0001,
  parameter logic [W-1:0] CLR_CYC = 16'h0001
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Synchronised active-high cause in, qualified cause out
  input wire logic raw_active,
  output logic qual_active
);

  logic [W-1:0] run_q;
  logic [W-1:0] limit;
  logic qual_q;

  // Threshold depends on the direction of the pending change
  assign limit = qual_q ? CLR_CYC : SET_CYC;
  assign qual_active = qual_q;

  // Count consecutive cycles that disagree with the output; any agree cycle restarts
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run_q <= '0;
      qual_q <= 1'b0;
    end
    else if (raw_active == qual_q)
    begin
      run_q <= '0;
    end
    else if (run_q + 1'b1 >= limit)
    begin
      run_q <= '0;
      qual_q <= raw_active;
    end
    else
    begin
      run_q <= run_q + 1'b1;
    end
  end

endmodule

// ### hdl/ssr_pkg.sv
// Shared timing constants and encodings for the supply supervisor reset timer
package ssr_pkg;

  // Core clock
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Reset timeout period, typical figure, in milliseconds
  localparam int unsigned TIMEOUT_MS = 190;
  localparam int unsigned TIMEOUT_MIN_MS = 100;
  localparam int unsigned TIMEOUT_MAX_MS = 560;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);

  // Manual input: lows longer than the glitch time are qualified
  localparam int unsigned MAN_GLITCH_NS = 100;
  localparam int unsigned MAN_QUAL_CYC = MAN_GLITCH_NS / CLK_PERIOD_NS + 1;

  // Manual input: typical delay from falling edge to reset
  localparam int unsigned MAN_DELAY_US = 2;
  localparam int unsigned MAN_DELAY_CYC = (MAN_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned MAN_WAIT_CYC = MAN_DELAY_CYC - MAN_QUAL_CYC;

  // Manual input: least guaranteed low time a driver must give
  localparam int unsigned MAN_MIN_PULSE_US = 10;

  // Supply dip tolerance: shallow dip and deep dip
  localparam int unsigned SUPPLY_GLITCH_US = 40;
  localparam int unsigned SUPPLY_QUAL_CYC = (SUPPLY_GLITCH_US * 1000) / CLK_PERIOD_NS + 1;
  localparam int unsigned SUPPLY_DEEP_US = 10;
  localparam int unsigned SUPPLY_DEEP_CYC = (SUPPLY_DEEP_US * 1000) / CLK_PERIOD_NS + 1;

  // Release of a supply cause is taken without delay; the timeout filters it
  localparam int unsigned SUPPLY_REL_CYC = 1;

  // Counter widths
  localparam int unsigned CNT_W = 32;
  localparam int unsigned FLT_W = 16;

  // Output levels
  localparam logic RST_ASSERTED = 1'b0;
  localparam logic RST_RELEASED = 1'b1;

  // Sequencer states
  typedef enum logic [1:0] {
    SSR_HOLD,
    SSR_TIMEOUT,
    SSR_RUN
  } ssr_state_t;

endpackage

// ### hdl/ssr_top.sv
// Supervisory reset generator: supply and manual causes, glitch filters, timeout
`timescale 1ns/1ns
module ssr_top
  import ssr_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = ssr_pkg::TIMEOUT_CYC,
  parameter int unsigned SUPPLY_QUAL_CYCLES = ssr_pkg::SUPPLY_QUAL_CYC,
  parameter int unsigned SUPPLY_DEEP_CYCLES = ssr_pkg::SUPPLY_DEEP_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Comparator results, high while supply is below the trip level
  input wire logic SUPPLY_LOW,
  input wire logic SUPPLY_DEEP_LOW,
  // Manual reset pin, active low
  input wire logic MANUAL_RESET_IN_N,
  // Reset to the processor, open-drain style
  output logic RST_OUT_N,
  output logic RST_OUT_OE
);

  import ssr_pkg::*;

  localparam logic [FLT_W-1:0] MAN_QUAL_W = FLT_W'(MAN_QUAL_CYC);
  localparam logic [FLT_W-1:0] SUP_REL_W = FLT_W'(SUPPLY_REL_CYC);
  localparam logic [FLT_W-1:0] SUP_QUAL_W = FLT_W'(SUPPLY_QUAL_CYCLES);
  localparam logic [FLT_W-1:0] SUP_DEEP_W = FLT_W'(SUPPLY_DEEP_CYCLES);
  localparam logic [CNT_W-1:0] TIMEOUT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
  localparam logic [CNT_W-1:0] MAN_WAIT_LAST = CNT_W'(MAN_WAIT_CYC - 1);

  logic [1:0] sup_sync_q;
  logic [1:0] deep_sync_q;
  logic [1:0] man_sync_q;
  logic sup_low_f;
  logic deep_low_f;
  logic man_low_f;
  logic man_low_prev_q;
  logic man_pend_q;
  logic man_fire_q;
  logic [CNT_W-1:0] man_cnt_q;
  logic [CNT_W-1:0] tmo_cnt_q;
  ssr_state_t state_q;
  ssr_state_t state_d;
  logic cause;

  // Two-stage synchronisers; only the second stage is read by logic
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sup_sync_q <= 2'h3;
      deep_sync_q <= 2'h3;
      man_sync_q <= 2'h3;
    end
    else
    begin
      sup_sync_q <= {sup_sync_q[0], SUPPLY_LOW};
      deep_sync_q <= {deep_sync_q[0], SUPPLY_DEEP_LOW};
      man_sync_q <= {man_sync_q[0], MANUAL_RESET_IN_N};
    end
  end

  // Shallow dips must outlast the long window before they count
  ssr_glitch_filter #(
    .W(FLT_W),
    .SET_CYC(SUP_QUAL_W),
    .CLR_CYC(SUP_REL_W)
  ) u_sup_flt (
    .clk(CORE_CLK),
    .reset_n(RESET_N),
    .raw_active(sup_sync_q[1]),
    .qual_active(sup_low_f)
  );

  // Deeper dips qualify in a shorter window, giving the falling tolerance curve
  ssr_glitch_filter #(
    .W(FLT_W),
    .SET_CYC(SUP_DEEP_W),
    .CLR_CYC(SUP_REL_W)
  ) u_deep_flt (
    .clk(CORE_CLK),
    .reset_n(RESET_N),
    .raw_active(deep_sync_q[1]),
    .qual_active(deep_low_f)
  );

  // Manual input is debounced in both directions with the glitch window
  ssr_glitch_filter #(
    .W(FLT_W),
    .SET_CYC(MAN_QUAL_W),
    .CLR_CYC(MAN_QUAL_W)
  ) u_man_flt (
    .clk(CORE_CLK),
    .reset_n(RESET_N),
    .raw_active(~man_sync_q[1]),
    .qual_active(man_low_f)
  );

  // Edge memory for the qualified manual low
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      man_low_prev_q <= 1'b0;
    end
    else
    begin
      man_low_prev_q <= man_low_f;
    end
  end

  // Propagation delay: once qualified, the request always fires, even if released early
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      man_pend_q <= 1'b0;
      man_cnt_q <= '0;
    end
    else if (man_low_f && !man_low_prev_q && !man_pend_q && !man_fire_q)
    begin
      man_pend_q <= 1'b1;
      man_cnt_q <= '0;
    end
    else if (man_pend_q && man_cnt_q >= MAN_WAIT_LAST)
    begin
      man_pend_q <= 1'b0;
      man_cnt_q <= '0;
    end
    else if (man_pend_q)
    begin
      man_cnt_q <= man_cnt_q + 1'b1;
    end
  end

  // Manual cause: set by the delay expiry, held while the input stays low
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      man_fire_q <= 1'b0;
    end
    else if (man_pend_q && man_cnt_q >= MAN_WAIT_LAST)
    begin
      man_fire_q <= 1'b1;
    end
    else if (!man_low_f)
    begin
      man_fire_q <= 1'b0;
    end
  end

  // Any live cause forces the hold state
  assign cause = sup_low_f | deep_low_f | man_fire_q;

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SSR_HOLD:
      begin
        if (!cause)
        begin
          state_d = SSR_TIMEOUT;
        end
      end
      SSR_TIMEOUT:
      begin
        if (cause)
        begin
          state_d = SSR_HOLD;
        end
        else if (tmo_cnt_q >= TIMEOUT_LAST)
        begin
          state_d = SSR_RUN;
        end
      end
      SSR_RUN:
      begin
        if (cause)
        begin
          state_d = SSR_HOLD;
        end
      end
      default:
      begin
        state_d = SSR_HOLD;
      end
    endcase
  end

  // State register; power-up enters hold so the full timeout always runs
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_q <= SSR_HOLD;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Timeout counter restarts from zero on every entry, so good time must be continuous
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tmo_cnt_q <= '0;
    end
    else if (state_q == SSR_TIMEOUT && !cause)
    begin
      tmo_cnt_q <= tmo_cnt_q + 1'b1;
    end
    else
    begin
      tmo_cnt_q <= '0;
    end
  end

  // Output flops; enable is high while the pin is pulled low
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      RST_OUT_N <= RST_ASSERTED;
      RST_OUT_OE <= 1'b1;
    end
    else
    begin
      RST_OUT_N <= (state_d == SSR_RUN) ? RST_RELEASED : RST_ASSERTED;
      RST_OUT_OE <= (state_d != SSR_RUN);
    end
  end

endmodule

// ### test/ssr_proc_model.sv
// Processor reset pin and external manual reset logic
`timescale 1ns/1ns
module ssr_proc_model (
  // From the timer
  input wire logic rst_oe,
  // External logic pulling the manual pin low
  input wire logic pull_low,
  // Resolved pin levels
  output logic rst_line,
  output logic man_pin
);
  // Pull-up on the open-drain reset line
  assign rst_line = rst_oe ? 1'b0 : 1'b1;
  // Pull-up keeps an undriven manual pin inactive
  assign man_pin = pull_low ? 1'b0 : 1'b1;
endmodule

// ### test/ssr_top_assertions.sv
// Port-level checks on the supervisory reset timer
`timescale 1ns/1ns
module ssr_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 50,
  parameter int unsigned SUPPLY_QUAL_CYCLES = 20,
  parameter int unsigned SUPPLY_DEEP_CYCLES = 8
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Reset causes
  input wire logic SUPPLY_LOW,
  input wire logic SUPPLY_DEEP_LOW,
  input wire logic MANUAL_RESET_IN_N,
  // Reset output
  input wire logic RST_OUT_N,
  input wire logic RST_OUT_OE
);
  logic [31:0] sl_q, dl_q, good_q, man_lo_q, man_hi_q;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  // Run lengths of each cause; wide enough that real timeouts never wrap
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sl_q <= 32'h0;
      dl_q <= 32'h0;
      good_q <= 32'h0;
      man_lo_q <= 32'h0;
      man_hi_q <= 32'h0;
    end
    else
    begin
      sl_q <= SUPPLY_LOW ? sl_q + 32'h1 : 32'h0;
      dl_q <= SUPPLY_DEEP_LOW ? dl_q + 32'h1 : 32'h0;
      good_q <= (SUPPLY_LOW | SUPPLY_DEEP_LOW) ? 32'h0 : good_q + 32'h1;
      man_lo_q <= MANUAL_RESET_IN_N ? 32'h0 : man_lo_q + 32'h1;
      man_hi_q <= MANUAL_RESET_IN_N ? man_hi_q + 32'h1 : 32'h0;
    end
  end

  property p_oe_inv;
    RST_OUT_OE == !RST_OUT_N;
  endproperty
  a_oe_inv: assert property (p_oe_inv) else $error("enable not inverse of reset");
  property p_reset_hold;
    $rose(RESET_N) |-> !RST_OUT_N [*8];
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("early power-up release");
  property p_sup_assert;
    sl_q >= SUPPLY_QUAL_CYCLES + 6 |-> !RST_OUT_N;
  endproperty
  a_sup_assert: assert property (p_sup_assert) else $error("low supply not reset");
  property p_deep_assert;
    dl_q >= SUPPLY_DEEP_CYCLES + 6 |-> !RST_OUT_N;
  endproperty
  a_deep_assert: assert property (p_deep_assert) else $error("deep dip not reset");
  property p_man_delay;
    man_lo_q == 32'h1e |-> ##[460:490] !RST_OUT_N;
  endproperty
  a_man_delay: assert property (p_man_delay) else $error("manual reset delay off");
  property p_man_hold;
    man_lo_q >= 32'h203 |-> !RST_OUT_N;
  endproperty
  a_man_hold: assert property (p_man_hold) else $error("held manual not reset");
  property p_rise_supply;
    $rose(RST_OUT_N) |-> good_q >= TIMEOUT_CYCLES;
  endproperty
  a_rise_supply: assert property (p_rise_supply) else $error("release before timeout");
  property p_rise_manual;
    $rose(RST_OUT_N) |-> man_hi_q >= TIMEOUT_CYCLES;
  endproperty
  a_rise_manual: assert property (p_rise_manual) else $error("manual release early");
  property p_release_bound;
    good_q >= TIMEOUT_CYCLES + 12 && man_hi_q >= TIMEOUT_CYCLES + 560 |-> RST_OUT_N;
  endproperty
  a_release_bound: assert property (p_release_bound) else $error("release too late");
endmodule

bind ssr_top ssr_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .SUPPLY_QUAL_CYCLES(SUPPLY_QUAL_CYCLES), .SUPPLY_DEEP_CYCLES(SUPPLY_DEEP_CYCLES)) u_chk (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .SUPPLY_LOW(SUPPLY_LOW),
  .SUPPLY_DEEP_LOW(SUPPLY_DEEP_LOW), .MANUAL_RESET_IN_N(MANUAL_RESET_IN_N),
  .RST_OUT_N(RST_OUT_N), .RST_OUT_OE(RST_OUT_OE));

// ### test/tb_top.sv
// Self-checking bench for the supervisory reset timer
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  num_checks++; \
  if ((g) !== (e)) \
  begin \
    failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end
module tb_top;
  import ssr_pkg::*;
  localparam int TO = 50;
  localparam int SQ = 20;
  localparam int DQ = 8;
  typedef struct {logic v; int lo; int hi;} ssr_note_t;
  ssr_note_t notes[$];
  ssr_note_t n;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic s_low = 1'b0;
  logic d_low = 1'b0;
  logic pull = 1'b0;
  logic armed = 1'b0;
  logic prev = 1'b0;
  logic man_pin, rst_out_n, rst_oe, rst_line;
  logic [31:0] seed = 32'h0a5d4034;
  int cyc = 0;
  int failures = 0;
  int num_checks = 0;
  int t0;
  // 250 MHz core clock and cycle count
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  ssr_top #(.TIMEOUT_CYCLES(TO), .SUPPLY_QUAL_CYCLES(SQ), .SUPPLY_DEEP_CYCLES(DQ)) uut (
    .CORE_CLK(clk), .RESET_N(rst_n), .SUPPLY_LOW(s_low), .SUPPLY_DEEP_LOW(d_low),
    .MANUAL_RESET_IN_N(man_pin), .RST_OUT_N(rst_out_n), .RST_OUT_OE(rst_oe));
  ssr_proc_model u_proc (.rst_oe(rst_oe), .pull_low(pull), .rst_line(rst_line),
    .man_pin(man_pin));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic close_out();
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hold one cause for len cycles and note the edges it must give (negative: none)
  task automatic pulse(input int sel, input int len, input int flo, input int fhi,
                       input int rlo, input int rhi);
    @(negedge clk);
    t0 = cyc;
    if (flo >= 0) notes.push_back('{1'b0, t0 + flo, t0 + fhi});
    if (rlo >= 0) notes.push_back('{1'b1, t0 + len + rlo, t0 + len + rhi});
    if (sel == 0) s_low = 1'b1;
    else if (sel == 1) d_low = 1'b1;
    else pull = 1'b1;
    repeat (len) @(negedge clk);
    s_low = 1'b0;
    d_low = 1'b0;
    pull = 1'b0;
    repeat (rhi > 0 ? rhi + 20 : 12) @(negedge clk);
  endtask
  // Each edge on the reset line takes the oldest note; an edge with none is a spurious pulse
  always @(posedge clk)
  begin
    if (armed && rst_line !== prev)
    begin
      n = '{prev, 0, -1};
      if (notes.size() > 0)
        n = notes.pop_front();
      `CHK("reset level", n.v, rst_line)
      `CHK("edge in window", 1'b1, cyc >= n.lo && cyc <= n.hi)
      `CHK("pin drive", rst_line, rst_out_n)
    end
    prev <= rst_line;
  end
  initial
  begin
    repeat (6) @(negedge clk);
    notes.push_back('{1'b1, cyc + TO, cyc + TO + 8});
    rst_n = 1'b1;
    armed = 1'b1;
    repeat (TO + 20) @(negedge clk);
    pulse(0, SQ - 1, -1, 0, -1, -1);
    pulse(0, 40, SQ, SQ + 8, TO, TO + 8);
    pulse(0, 30, SQ, SQ + 8, -1, -1);
    pulse(0, 30, -1, 0, TO, TO + 8);
    pulse(1, DQ - 1, -1, 0, -1, -1);
    pulse(1, 20, DQ, DQ + 8, TO, TO + 8);
    pulse(2, 25, -1, 0, -1, -1);
    pulse(2, 40, 495, 512, TO + 440, TO + 480);
    pulse(2, 2600, 495, 512, TO, TO + 40);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      pulse(seed[8], 1 + seed[31:16] % (seed[8] ? DQ - 1 : SQ - 1), -1, 0, -1, -1);
    end
    @(negedge clk);
    notes.push_back('{1'b0, cyc, cyc + 2});
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    notes.push_back('{1'b1, cyc + TO, cyc + TO + 8});
    rst_n = 1'b1;
    for (int i = 0; i < TO + 100 && notes.size() > 0; i++)
      @(negedge clk);
    `CHK("missing edges", 0, notes.size())
    close_out();
  end
  // Cut a hung run short
  initial
  begin
    repeat (12000) @(posedge clk);
    `CHK("run length", 1'b0, 1'b1)
    close_out();
  end
endmodule
